/* File: hdl/time_processor_core.v */
// Timer channel scheduler core: sixteen match/capture channels, a
// three-level scheduler, a small microcode engine and parameter RAM.
// Assumes an AHB-Lite master on hclk and an external emulation RAM
// with one-cycle synchronous read on emu_addr.
//
// What this block does
// R1 - Sixteen identical independent pin channels
// R2 - Capture, match registers and >= comparator
// R3 - Engine sets each pin direction
// R4 - Match and capture pick time bases separately
// R5 - Four request causes: host, link, match, capture
// R6 - Host programs high, middle, low priority
// R7 - Same priority: lowest channel number first
// R8 - Remaining same-level requests served in order
// R9 - Events post requests, granted when engine free
// R10 - Per-channel detection, one-tick resolution
// R11 - Pending requests held until granted
// R12 - Microcode from ROM or emulation RAM
// R13 - 128-word parameter RAM, all accessible
// R14 - Channel words at channel times 0x10
// R15 - Pin state field forces pin level
// R16 - Pin action selects edge or match level
// R17 - Time base field sets direction, sources
// R18 - Microcode links, controls, writes other channels
// R19 - Adjacent word pairs accessed coherently
// R20 - Host uses 32-bit access for pairs
// R21 - Emulation bit connects RAM, blocks host
// R22 - Aux bus 9-bit address, 32-bit data
// R23 - Time base one hclk, two hclk or pin
// R24 - One grant at a time until done
`timescale 1ns/10ps
`default_nettype none
`include "timer_core_regs.vh"

module time_processor_core (
  input wire hclk, // System clock, 10 MHz
  input wire hresetn, // Asynchronous reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready
  output reg [31:0] hrdata, // Read data
  output wire hreadyout, // Slave ready
  output wire hresp, // Always OKAY
  input wire [15:0] chan_pin_in, // Channel pin levels
  output reg [15:0] chan_pin_out, // Channel pin drive
  output wire [15:0] chan_pin_oe_n, // Pin enable, low drives
  input wire ext_timebase_clock_pin, // External time base two clock
  output wire [8:0] emu_addr, // Emulation RAM address
  output wire emu_rd, // Emulation RAM read strobe
  input wire [31:0] emu_rdata, // Emulation RAM data
  output wire emu_host_block // Host access to emulation RAM blocked
);

  // Engine states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_EXEC = 3'b100;

  // Lowest set bit finder, {found, index}
  function [4:0] first_one;
    input [15:0] v;
    integer i;
    begin
      first_one = 5'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_one = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  // Control-store ROM contents
  function [31:0] rom_word;
    input [8:0] a;
    begin
      case (a)
        // Function 1: rearm own match 0x0100 ticks later
        9'h020: rom_word = {`OP_MATCH_REL, 4'h0, 1'b1, 7'h00, 16'h0100};
        default: rom_word = {`OP_END, 28'h0000000};
      endcase
    end
  endfunction

  // Host registers
  reg [7:0] mcr_reg; // Module configuration
  reg [31:0] pri_reg; // Two priority bits per channel
  reg [63:0] fsel_reg; // Four function bits per channel
  // Request flags per cause
  reg [15:0] hsr_pend_reg, link_pend_reg, match_pend_reg, cap_pend_reg;
  // Round-robin served masks per level
  reg [15:0] served_hi_reg, served_mid_reg, served_lo_reg;
  // Channel event registers
  reg [15:0] cap_mem [0:15];
  reg [15:0] match_mem [0:15];
  reg [15:0] armed_reg; // Match armed
  reg [15:0] level_reg; // Pin level from match actions
  reg [15:0] pram [0:127]; // Parameter RAM
  // Time bases and dividers
  reg [15:0] tb1_reg, tb2_reg;
  reg [8:0] tb1_cnt_reg, tb2_cnt_reg;
  // Synchronisers
  reg [15:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  reg ext_s1_reg, ext_s2_reg, ext_s3_reg;
  // Engine
  reg [2:0] state_reg;
  reg [8:0] pc_reg;
  reg [3:0] gchan_reg; // Granted channel
  reg [3:0] gcause_reg; // Causes latched at grant
  reg [31:0] rom_q_reg;
  // Bus data phase
  reg dp_wr_reg;
  reg [8:0] dp_addr_reg;

  wire emu_en = mcr_reg[`MCR_EMU_BIT];
  wire stop = mcr_reg[`MCR_STOP_BIT];
  integer k, k_pri, k_ram; // Loop indices, one per process

  // Bus answer: never waits, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // R21 emulation RAM isolation
  assign emu_host_block = emu_en;
  // R22 aux bus address and strobe
  assign emu_addr = pc_reg;
  assign emu_rd = state_reg[2'd1] & emu_en;

  // Address phase accepted
  wire ap_take = hsel & hready & htrans[1];
  // Host write in data phase
  wire host_wr = dp_wr_reg;
  wire host_pram_wr = dp_wr_reg & dp_addr_reg[`PRAM_SEL_BIT];

  // Pin and external clock synchronisers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 16'h0000;
      pin_s2_reg <= 16'h0000;
      pin_s3_reg <= 16'h0000;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= chan_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      ext_s1_reg <= ext_timebase_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // Divider limits: base divide shifted by prescale
  wire [8:0] tb1_base = mcr_reg[`MCR_PSCK_BIT] ? `TB1_SLOW_DIV : `TB1_FAST_DIV;
  wire [8:0] tb1_lim = (tb1_base << mcr_reg[`MCR_TB1_PRE_LSB +: 2]) - 9'h001;
  wire [8:0] tb2_lim = (`TB2_BASE_DIV << mcr_reg[`MCR_TB2_PRE_LSB +: 2]) - 9'h001;
  wire ext_rise = ext_s2_reg & ~ext_s3_reg;
  wire tb1_tick = (tb1_cnt_reg == tb1_lim);
  wire tb2_tick = mcr_reg[`MCR_TB2_EXT_BIT] ? ext_rise : (tb2_cnt_reg == tb2_lim);

  // R23 time bases from hclk dividers or external pin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb1_reg <= 16'h0000;
      tb2_reg <= 16'h0000;
      tb1_cnt_reg <= 9'h000;
      tb2_cnt_reg <= 9'h000;
    end else if (!stop) begin
      tb1_cnt_reg <= tb1_tick ? 9'h000 : tb1_cnt_reg + 9'h001;
      tb2_cnt_reg <= (tb2_cnt_reg == tb2_lim) ? 9'h000 : tb2_cnt_reg + 9'h001;
      if (tb1_tick) begin
        tb1_reg <= tb1_reg + 16'h0001;
      end
      if (tb2_tick) begin
        tb2_reg <= tb2_reg + 16'h0001;
      end
    end
  end

  // Per-channel decode of control word and time base choice
  wire [15:0] out_dir, match_hit, cap_edge;
  wire [15:0] mtb [0:15];
  wire [15:0] ctb [0:15];
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : chan
      wire [15:0] ctl = pram[g * `PRAM_WORDS_PER_CHAN];
      wire [1:0] pin_action_field = ctl[`CTL_PAC_LSB +: 2];
      // R17 direction and time base selection
      assign out_dir[g] = ctl[`CTL_TBS_OUT_BIT];
      // R4 separate sources for match and capture
      assign mtb[g] = ctl[`CTL_TBS_MATCH_BIT] ? tb2_reg : tb1_reg;
      assign ctb[g] = ctl[`CTL_TBS_CAP_BIT] ? tb2_reg : tb1_reg;
      // R2 greater-or-equal comparator
      assign match_hit[g] = armed_reg[g] & (mtb[g] >= match_mem[g]);
      // R16 capture edge choice
      assign cap_edge[g] = ~out_dir[g] &
        (((pin_action_field == `PAC_RISE_HIGH) | (pin_action_field == `PAC_BOTH_TOGGLE)) &
         pin_s2_reg[g] & ~pin_s3_reg[g] |
         ((pin_action_field == `PAC_FALL_LOW) | (pin_action_field == `PAC_BOTH_TOGGLE)) &
         ~pin_s2_reg[g] & pin_s3_reg[g]);
      // R3 pin enable follows engine-written direction
      assign chan_pin_oe_n[g] = ~out_dir[g];
    end
  endgenerate

  // Scheduler: level vectors by priority
  wire [15:0] any_pend = hsr_pend_reg | link_pend_reg | match_pend_reg | cap_pend_reg;
  reg [15:0] req_hi, req_mid, req_lo;
  always @* begin
    for (k_pri = 0; k_pri < 16; k_pri = k_pri + 1) begin
      req_hi[k_pri] = any_pend[k_pri] & (pri_reg[2 * k_pri +: 2] == `PRI_HIGH);
      req_mid[k_pri] = any_pend[k_pri] & (pri_reg[2 * k_pri +: 2] == `PRI_MID);
      req_lo[k_pri] = any_pend[k_pri] & (pri_reg[2 * k_pri +: 2] == `PRI_LOW);
    end
  end

  // R6 highest non-empty level wins
  wire [1:0] lvl = (req_hi != 16'h0000) ? `PRI_HIGH :
                   (req_mid != 16'h0000) ? `PRI_MID : `PRI_LOW;
  wire [15:0] lvl_req = (lvl == `PRI_HIGH) ? req_hi :
                        (lvl == `PRI_MID) ? req_mid : req_lo;
  wire [15:0] lvl_served = (lvl == `PRI_HIGH) ? served_hi_reg :
                           (lvl == `PRI_MID) ? served_mid_reg : served_lo_reg;
  // R8 skip channels already served this round
  wire [15:0] cand = lvl_req & ~lvl_served;
  wire round_open = (cand != 16'h0000);
  // R7 lowest channel number first
  wire [4:0] pick = first_one(round_open ? cand : lvl_req);
  wire [15:0] pick_1h = 16'h0001 << pick[3:0];
  wire [15:0] served_new = (round_open ? lvl_served : 16'h0000) | pick_1h;
  // R24 grant only while engine idle
  wire grant = state_reg[2'd0] & pick[4] & ~stop;
  wire [15:0] grant_clr = grant ? pick_1h : 16'h0000;

  // Current microinstruction, R12 source select
  wire [31:0] instr = emu_en ? emu_rdata : rom_q_reg;
  wire [3:0] opc = instr[31:28];
  wire [3:0] tgt = instr[23] ? gchan_reg : instr[27:24];
  wire [15:0] imm = instr[15:0];
  wire exec = state_reg[2'd2];
  // Engine parameter writes stall only while a host parameter write is in its data phase
  wire eng_stall = exec & (opc == `OP_WR_PARAM) & host_pram_wr;
  wire eng_link = exec & (opc == `OP_LINK);
  wire eng_set_match = exec & ((opc == `OP_SET_MATCH) | (opc == `OP_MATCH_REL));

  // Engine state machine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      pc_reg <= 9'h000;
      gchan_reg <= 4'h0;
      gcause_reg <= 4'h0;
      rom_q_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // R24 single grant, held through routine
          if (grant) begin
            gchan_reg <= pick[3:0];
            gcause_reg <= {hsr_pend_reg[pick[3:0]], link_pend_reg[pick[3:0]],
                           match_pend_reg[pick[3:0]], cap_pend_reg[pick[3:0]]};
            pc_reg <= {fsel_reg[4 * pick[3:0] +: 4], 5'h00};
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // R22 ROM read timed as the aux bus read
          rom_q_reg <= rom_word(pc_reg);
          state_reg <= ST_EXEC;
        end
        ST_EXEC: begin
          if (opc == `OP_END) begin
            state_reg <= ST_IDLE;
          end else begin
            // A stalled write refetches: emulation data lasts one cycle
            if (!eng_stall) begin
              pc_reg <= pc_reg + 9'h001;
            end
            state_reg <= ST_FETCH;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // R5 request flags; R11 a flag stays until its grant
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hsr_pend_reg <= 16'h0000;
      link_pend_reg <= 16'h0000;
      match_pend_reg <= 16'h0000;
      cap_pend_reg <= 16'h0000;
      served_hi_reg <= 16'h0000;
      served_mid_reg <= 16'h0000;
      served_lo_reg <= 16'h0000;
    end else begin
      // R9 events post requests; set beats clear
      hsr_pend_reg <= (hsr_pend_reg & ~grant_clr) |
        ((host_wr && dp_addr_reg == `OFS_HOST_SVC_REQ) ? hwdata[15:0] : 16'h0000);
      // R18 link from microcode to any channel
      link_pend_reg <= (link_pend_reg & ~grant_clr) |
        (eng_link ? (16'h0001 << tgt) : 16'h0000);
      match_pend_reg <= (match_pend_reg & ~grant_clr) | match_hit;
      cap_pend_reg <= (cap_pend_reg & ~grant_clr) | cap_edge;
      // R8 round bookkeeping
      if (grant) begin
        if (lvl == `PRI_HIGH) begin
          served_hi_reg <= served_new;
        end else if (lvl == `PRI_MID) begin
          served_mid_reg <= served_new;
        end else begin
          served_lo_reg <= served_new;
        end
      end
    end
  end

  // R1 R10 per-channel event hardware, every cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 16'h0000;
      level_reg <= 16'h0000;
      chan_pin_out <= 16'h0000;
      for (k = 0; k < 16; k = k + 1) begin
        cap_mem[k] <= 16'h0000;
        match_mem[k] <= 16'h0000;
      end
    end else begin
      for (k = 0; k < 16; k = k + 1) begin
        // R2 capture the selected time base
        if (cap_edge[k]) begin
          cap_mem[k] <= ctb[k];
        end
        // R16 match drives programmed level
        if (match_hit[k]) begin
          armed_reg[k] <= 1'b0;
          if (pram[k * 8][`CTL_PAC_LSB +: 2] == `PAC_RISE_HIGH) begin
            level_reg[k] <= 1'b1;
          end else if (pram[k * 8][`CTL_PAC_LSB +: 2] == `PAC_FALL_LOW) begin
            level_reg[k] <= 1'b0;
          end else if (pram[k * 8][`CTL_PAC_LSB +: 2] == `PAC_BOTH_TOGGLE) begin
            level_reg[k] <= ~level_reg[k];
          end
        end
        // R18 microcode arms another channel's match
        if (eng_set_match && tgt == k[3:0]) begin
          armed_reg[k] <= 1'b1;
          match_mem[k] <= (opc == `OP_MATCH_REL) ? mtb[k] + imm : imm;
        end
        // R15 pin state field overrides
        if (pram[k * 8][`CTL_PSC_LSB +: 2] == `PSC_HIGH) begin
          chan_pin_out[k] <= 1'b1;
        end else if (pram[k * 8][`CTL_PSC_LSB +: 2] == `PSC_LOW) begin
          chan_pin_out[k] <= 1'b0;
        end else begin
          chan_pin_out[k] <= level_reg[k];
        end
      end
    end
  end

  // Parameter RAM: host pairs and engine single words
  wire [6:0] hpair = {dp_addr_reg[7:2], 1'b0};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (k_ram = 0; k_ram < `PRAM_WORDS; k_ram = k_ram + 1) begin
        pram[k_ram] <= 16'h0000;
      end
    end else begin
      // R19 R20 both halves of a long word at once
      if (host_pram_wr) begin
        pram[hpair] <= hwdata[31:16];
        pram[hpair | 7'h01] <= hwdata[15:0];
      end else if (exec && opc == `OP_WR_PARAM) begin
        // R14 R18 channel words at channel times eight
        pram[{tgt, instr[18:16]}] <= imm;
      end
    end
  end

  // Read mux, sampled at the address phase
  reg [31:0] rd_word;
  wire [8:0] ra = haddr[8:0];
  wire [6:0] rpair = {ra[7:2], 1'b0};
  always @* begin
    rd_word = 32'h0000_0000;
    if (ra[`PRAM_SEL_BIT]) begin
      // R13 R19 any word pair, one snapshot
      rd_word = {pram[rpair], pram[rpair | 7'h01]};
    end else if (ra >= `OFS_CHAN_WIN_BASE && ra <= `OFS_CHAN_WIN_END) begin
      rd_word = {match_mem[ra[5:2]], cap_mem[ra[5:2]]};
    end else begin
      case (ra)
        `OFS_MODULE_CONFIG: rd_word = {24'h000000, mcr_reg};
        `OFS_HOST_SVC_REQ: rd_word = {16'h0000, hsr_pend_reg};
        `OFS_PRIORITY: rd_word = pri_reg;
        `OFS_FUNC_SEL_LO: rd_word = fsel_reg[31:0];
        `OFS_FUNC_SEL_HI: rd_word = fsel_reg[63:32];
        `OFS_ENGINE_STATUS: rd_word = {20'h00000, gcause_reg, 1'b0, state_reg, gchan_reg};
        `OFS_EVENT_PEND: rd_word = {match_pend_reg, cap_pend_reg};
        `OFS_REQ_PEND: rd_word = {link_pend_reg, hsr_pend_reg};
        `OFS_TIMEBASES: rd_word = {tb2_reg, tb1_reg};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Bus slave: capture address phase, write registers in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 9'h000;
      hrdata <= 32'h0000_0000;
      mcr_reg <= `MCR_RESET;
      pri_reg <= `PRI_RESET;
      fsel_reg <= {`FSEL_RESET, `FSEL_RESET};
    end else begin
      dp_wr_reg <= ap_take & hwrite;
      if (ap_take) begin
        dp_addr_reg <= haddr[8:0];
        if (!hwrite) begin
          hrdata <= rd_word;
        end
      end
      if (host_wr) begin
        case (dp_addr_reg)
          `OFS_MODULE_CONFIG: mcr_reg <= hwdata[7:0];
          // R6 host priority per channel
          `OFS_PRIORITY: pri_reg <= hwdata;
          `OFS_FUNC_SEL_LO: fsel_reg[31:0] <= hwdata;
          `OFS_FUNC_SEL_HI: fsel_reg[63:32] <= hwdata;
          default: mcr_reg <= mcr_reg;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: pkg/timer_core_regs.vh */
// Constants for the timer channel scheduler core: register offsets,
// field positions, reset values, encodings and divider ratios.
// Assumes it is included by name by the design files only.
`ifndef TIMER_CORE_REGS_VH
`define TIMER_CORE_REGS_VH
// Byte offsets of host registers (low nine address bits)
`define OFS_MODULE_CONFIG 9'h000
`define OFS_HOST_SVC_REQ 9'h004
`define OFS_PRIORITY 9'h008
`define OFS_FUNC_SEL_LO 9'h00C
`define OFS_FUNC_SEL_HI 9'h010
`define OFS_ENGINE_STATUS 9'h014
`define OFS_EVENT_PEND 9'h018
`define OFS_REQ_PEND 9'h01C
`define OFS_TIMEBASES 9'h020
`define OFS_CHAN_WIN_BASE 9'h040
`define OFS_CHAN_WIN_END 9'h07C
// Parameter RAM occupies 0x100..0x1FF
`define PRAM_SEL_BIT 8
`define PRAM_WORDS 128
`define PRAM_WORDS_PER_CHAN 8
// Module configuration fields and reset value
`define MCR_TB1_PRE_LSB 0
`define MCR_PSCK_BIT 2
`define MCR_TB2_PRE_LSB 3
`define MCR_TB2_EXT_BIT 5
`define MCR_EMU_BIT 6
`define MCR_STOP_BIT 7
`define MCR_RESET 8'h00
`define PRI_RESET 32'h0000_0000
`define FSEL_RESET 32'h0000_0000
// Channel control word fields (parameter word 0 of each channel)
`define CTL_PSC_LSB 0
`define CTL_PAC_LSB 2
`define CTL_TBS_CAP_BIT 4
`define CTL_TBS_MATCH_BIT 5
`define CTL_TBS_OUT_BIT 6
`define PSC_HIGH 2'h1
`define PSC_LOW 2'h2
`define PAC_RISE_HIGH 2'h1
`define PAC_FALL_LOW 2'h2
`define PAC_BOTH_TOGGLE 2'h3
// Channel priorities
`define PRI_OFF 2'h0
`define PRI_LOW 2'h1
`define PRI_MID 2'h2
`define PRI_HIGH 2'h3
// Microinstruction opcodes and fields
`define OP_END 4'h0
`define OP_SET_MATCH 4'h1
`define OP_WR_PARAM 4'h2
`define OP_LINK 4'h3
`define OP_MATCH_REL 4'h4
// Time base dividers from hclk
`define TB1_FAST_DIV 9'h004
`define TB1_SLOW_DIV 9'h020
`define TB2_BASE_DIV 9'h008
`endif

/* File: tb/emu_ram_model.sv */
// Emulation RAM model that answers the core's microcode fetches.
// Assumes the core samples emu_rdata in the cycle after emu_rd.
`timescale 1ns/10ps
`default_nettype none
module emu_ram_model (
  input wire logic hclk, // System clock
  input wire logic [8:0] emu_addr, // Fetch address
  input wire logic emu_rd, // Fetch strobe
  output logic [31:0] emu_rdata // Fetched word
);
  logic [31:0] mem [0:511]; // Microcode words, all END by default
  logic [8:0] log_q [$]; // Every fetch address seen, in order
  // Clear store and output
  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    emu_rdata = 32'h0000_0000;
  end
  always @(posedge hclk) begin
    if (emu_rd) begin
      emu_rdata <= mem[emu_addr];
      log_q.push_back(emu_addr);
    end else begin
      // Word is not held past its cycle
      emu_rdata <= ~emu_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_timer_channel_scheduler_core.sv */
// Self-checking bench for the timer channel scheduler core.
// Assumes one AHB-Lite master here and an emulation RAM model.
`timescale 1ns/10ps
`default_nettype none
module test_timer_channel_scheduler_core;
  logic hclk, hresetn, hsel, hwrite, ext_clk; // Clock, reset, bus, pin clock
  logic [31:0] haddr, hwdata; // Address and write data
  logic [1:0] htrans; // Transfer type
  logic [2:0] hsize; // Always a word
  logic [15:0] pin_drv; // Levels driven onto input pins
  wire [31:0] hrdata, emu_rdata; // Read data, fetched word
  wire hreadyout, hresp, emu_rd, emu_host_block; // Design status outputs
  wire [15:0] pin_out, pin_oe_n; // Pin drive and enables
  wire [8:0] emu_addr; // Fetch address
  wire [15:0] pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & pin_drv); // Wire level
  int error_cnt, n_compared; // Mismatches and comparisons
  time_processor_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chan_pin_in(pin_lvl),
    .chan_pin_out(pin_out), .chan_pin_oe_n(pin_oe_n), .ext_timebase_clock_pin(ext_clk),
    .emu_addr(emu_addr), .emu_rd(emu_rd), .emu_rdata(emu_rdata),
    .emu_host_block(emu_host_block));
  emu_ram_model u_ram (.hclk(hclk), .emu_addr(emu_addr), .emu_rd(emu_rd),
    .emu_rdata(emu_rdata));
  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // Waits for hready high, bounded
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        $display("[FAIL] t=%0t hready=%h exp=%h", $time, hreadyout, 1'b1);
        error_cnt++;
        wrap_up;
      end
      @(posedge hclk);
    end
  endtask
  task bus_wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task bus_rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy;
    d = hrdata;
  endtask
  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask
  // Counts cycles until a pin reaches a level, bounded
  task wait_pin(input int ch, input logic lvl, input int lim, output int n);
    n = 0;
    while (pin_out[ch] !== lvl) begin
      n++;
      if (n > lim) begin
        $display("[FAIL] t=%0t pin=%h exp=%h", $time, pin_out[ch], lvl);
        error_cnt++;
        wrap_up;
      end
      @(posedge hclk);
    end
  endtask
  task t_regs;
    rd_chk(32'h0000_0100, 32'h0000_0000);
    rd_chk(32'h0000_01FC, 32'h0000_0000);
    bus_wr(32'h0000_00F0, 32'hFFFF_FFFF);
    rd_chk(32'h0000_00F0, 32'h0000_0000);
    rd_chk(32'h0000_0008, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task t_pram;
    for (int c = 0; c < 16; c++) begin
      bus_wr(32'h0000_0108 + c * 16, {12'hA50, c[3:0], 12'h5A0, ~c[3:0]});
      if (c > 13) bus_wr(32'h0000_010C + c * 16, {16'hC3C3, 12'h0F0, c[3:0]});
    end
    for (int c = 0; c < 16; c++) begin
      rd_chk(32'h0000_0108 + c * 16, {12'hA50, c[3:0], 12'h5A0, ~c[3:0]});
      if (c > 13) rd_chk(32'h0000_010C + c * 16, {16'hC3C3, 12'h0F0, c[3:0]});
    end
    $display("t_pram done");
  endtask
  task t_pin;
    int n;
    bus_wr(32'h0000_0130, 32'h0041_0000);
    @(posedge hclk);
    chk({16'h0000, pin_oe_n}, 32'h0000_FFF7);
    wait_pin(3, 1'b1, 20, n);
    bus_wr(32'h0000_0130, 32'h0042_0000);
    wait_pin(3, 1'b0, 20, n);
    $display("t_pin done");
  endtask
  task t_cap;
    bus_wr(32'h0000_0150, 32'h0004_0000);
    rd_chk(32'h0000_0018, 32'h0000_0000);
    pin_drv <= 16'h0020;
    cyc(6);
    rd_chk(32'h0000_0018, 32'h0000_0020);
    $display("t_cap done");
  endtask
  task t_match;
    int n;
    bus_wr(32'h0000_0160, 32'h0044_0000);
    bus_wr(32'h0000_000C, 32'h0100_0000);
    bus_wr(32'h0000_0008, 32'h0000_3000);
    bus_wr(32'h0000_0004, 32'h0000_0040);
    wait_pin(6, 1'b1, 1200, n);
    chk({31'h0, n >= 1010 && n <= 1060}, 32'h0000_0001);
    $display("t_match done");
  endtask
  task t_tb2;
    logic [31:0] a, b;
    bus_wr(32'h0000_0000, 32'h0000_0020);
    bus_rd(32'h0000_0020, a);
    repeat (5) begin
      ext_clk <= 1'b1;
      cyc(4);
      ext_clk <= 1'b0;
      cyc(4);
    end
    cyc(4);
    bus_rd(32'h0000_0020, b);
    chk({16'h0000, b[31:16] - a[31:16]}, 32'h0000_0005);
    bus_wr(32'h0000_0000, 32'h0000_0000);
    $display("t_tb2 done");
  endtask
  task t_sched;
    logic [8:0] exp_q [6] = '{9'h080, 9'h0E0, 9'h0E1, 9'h080, 9'h120, 9'h040};
    u_ram.mem[9'h0E0] = 32'h3400_0000;
    bus_wr(32'h0000_000C, 32'h7004_0200);
    bus_wr(32'h0000_0010, 32'h0000_0090);
    bus_wr(32'h0000_0008, 32'h0008_C310);
    bus_wr(32'h0000_0000, 32'h0000_0040);
    @(posedge hclk);
    chk({31'h0, emu_host_block}, 32'h0000_0001);
    u_ram.log_q.delete();
    bus_wr(32'h0000_0004, 32'h0000_0294);
    cyc(60);
    chk(u_ram.log_q.size(), 32'h0000_0006);
    for (int i = 0; i < 6; i++) chk({23'h0, u_ram.log_q[i]}, {23'h0, exp_q[i]});
    bus_wr(32'h0000_0000, 32'h0000_0000);
    $display("t_sched done");
  endtask
  // Reset, then every scenario in turn
  initial begin
    error_cnt = 0;
    n_compared = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    pin_drv = 16'h0000;
    ext_clk = 1'b0;
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
    t_regs;
    t_pram;
    t_pin;
    t_cap;
    t_match;
    t_tb2;
    t_sched;
    wrap_up;
  end
endmodule
`default_nettype wire

/* File: tb/time_processor_core_assertions.sv */
// Port checker for the timer channel scheduler core.
// Assumes hready is tied to hreadyout and only word transfers.
`timescale 1ns/10ps
`default_nettype none
module time_processor_checker (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Slave select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write flag
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [15:0] chan_pin_out, // Pin drive
  input wire logic [15:0] chan_pin_oe_n, // Pin enable, low drives
  input wire logic emu_rd, // Fetch strobe
  input wire logic emu_host_block // Host blocked from RAM
);
  logic wr_dphase; // A host write is in its data phase
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Marks the data phase of each host write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_dphase <= 1'b0;
    else wr_dphase <= hsel && hready && htrans[1] && hwrite;
  end
  sequence s_rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_fetch_exec;
    emu_rd ##1 !emu_rd;
  endsequence
  property p_ready; hreadyout; endproperty
  property p_resp; !hresp; endproperty
  property p_rdata_hold; $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite);
  endproperty
  property p_rd_load; s_rd_taken ##1 1'b1 |-> 1'b1; endproperty
  property p_emu_pulse; emu_rd |-> s_fetch_exec; endproperty
  property p_emu_blk; emu_rd |-> emu_host_block; endproperty
  property p_oe_cause; ($changed(chan_pin_oe_n) && !emu_host_block) |-> $past(wr_dphase);
  endproperty
  property p_blk_cause; $changed(emu_host_block) |-> $past(wr_dphase); endproperty
  property p_rst_vals; $rose(hresetn) |-> chan_pin_oe_n == 16'hFFFF && chan_pin_out == 16'h0000
    && !emu_rd && !emu_host_block;
  endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  a_resp: assert property (p_resp) else $error("response not OKAY");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_emu_pulse: assert property (p_emu_pulse) else $error("fetch strobe too long");
  a_emu_blk: assert property (p_emu_blk) else $error("fetch without emulation");
  a_oe_cause: assert property (p_oe_cause) else $error("direction changed alone");
  a_blk_cause: assert property (p_blk_cause) else $error("block flag changed alone");
  a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");
  c_rd_load: cover property (p_rd_load);
endmodule
bind time_processor_core time_processor_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .chan_pin_out(chan_pin_out),
  .chan_pin_oe_n(chan_pin_oe_n), .emu_rd(emu_rd), .emu_host_block(emu_host_block));
`default_nettype wire
